// file: src/coarse_gain_decode.sv
// Purpose: Decode one 4-bit coarse gain code to gain in tenths
// Assumes: Same clock as the register bank
// Notes: Output is registered so top outputs come from flip-flops
`timescale 1ns/1ns
module coarse_gain_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Code in, gain out
   input wire logic [3:0] code,
   output logic [4:0] gain_tenths
);
   import digitizer_ctrl_pkg::*;

   // Monotonic map, 0.5 at 0000 to 2.0 at 1111, reset to 1.2
   always_ff @(posedge clk) begin
      if (rst) begin
         gain_tenths <= 5'h0C;
      end else begin
         gain_tenths <= GAIN_BASE_TENTHS + {1'b0, code};
      end
   end
endmodule : coarse_gain_decode

// file: src/coarse_offset_decode.sv
// Purpose: Decode one 6-bit sign-magnitude coarse offset to signed counts
// Assumes: Same clock as the register bank
// Notes: Plus and minus zero both give zero counts
`timescale 1ns/1ns
module coarse_offset_decode (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Code in, signed counts out
   input wire logic [5:0] code,
   output logic signed [8:0] counts
);
   import digitizer_ctrl_pkg::*;

   logic [8:0] mag;

   // Four counts per magnitude step
   assign mag = {2'b00, code[4:0], 2'b00};

   // Apply sign bit, reset matches default +64
   always_ff @(posedge clk) begin
      if (rst) begin
         counts <= 9'sh040;
      end else if (code[COFS_SIGN_BIT]) begin
         counts <= -$signed(mag);
      end else begin
         counts <= $signed(mag);
      end
   end
endmodule : coarse_offset_decode

// file: src/digitizer_ctrl_pkg.sv
// Purpose: Constants for the sync, clock and offset control register group
// Assumes: 8-bit registers at 8-bit subaddresses on the serial control bus
// Notes: Every offset and register reset value lives here, with the select, control and sign bit field positions
package digitizer_ctrl_pkg;

   // Register subaddresses
   localparam logic [7:0] ADDR_INPUT_SEL2 = 8'h1A;
   localparam logic [7:0] ADDR_BG_GAIN = 8'h1B;
   localparam logic [7:0] ADDR_RED_GAIN = 8'h1C;
   localparam logic [7:0] ADDR_FINE_LSB = 8'h1D;
   localparam logic [7:0] ADDR_BLUE_COFS = 8'h1E;
   localparam logic [7:0] ADDR_GREEN_COFS = 8'h1F;
   localparam logic [7:0] ADDR_RED_COFS = 8'h20;
   localparam logic [7:0] ADDR_HS_START = 8'h21;
   localparam logic [7:0] ADDR_SP_CTRL = 8'h22;

   // Reset values
   localparam logic [7:0] RST_INPUT_SEL2 = 8'hC2;
   localparam logic [7:0] RST_BG_GAIN = 8'h77;
   localparam logic [7:0] RST_RED_GAIN = 8'h07;
   localparam logic [7:0] RST_FINE_LSB = 8'h00;
   localparam logic [7:0] RST_COFS = 8'h10;
   localparam logic [7:0] RST_HS_START = 8'h0D;
   localparam logic [7:0] RST_SP_CTRL = 8'h08;

   // Writable bit masks; reserved bits read zero
   localparam logic [7:0] MASK_RED_GAIN = 8'h0F;
   localparam logic [7:0] MASK_FINE_LSB = 8'h3F;
   localparam logic [7:0] MASK_COFS = 8'h3F;

   // Input select 2 field positions
   localparam int SOG_FILT_LSB = 6;
   localparam int CLP_FILT_LSB = 4;
   localparam int REF_CLK_BIT = 3;
   localparam int VS_IN_BIT = 2;
   localparam int SAMPLE_CLK_BIT = 1;
   localparam int HS_IN_BIT = 0;

   // Sync processing control field positions
   localparam int SYNC_PROCESSING_RESET_BIT = 7;
   localparam int LUMA_DLY_LSB = 4;
   localparam int STRIP_EN_BIT = 3;
   localparam int COAST_DIS_BIT = 2;
   localparam int VS_SRC_BIT = 1;
   localparam int VERTICAL_TIMING_BYPASS_BIT = 0;

   // Coarse offset: sign bit and counts per magnitude step
   localparam int COFS_SIGN_BIT = 5;
   localparam int COFS_STEP_SHIFT = 2;

   // Coarse gain in tenths: 0.5 at code 0, 0.1 per step
   localparam logic [4:0] GAIN_BASE_TENTHS = 5'h05;

   // Sync-on-green filter select encodings
   localparam logic [1:0] SOG_FILT_2M5 = 2'h0;
   localparam logic [1:0] SOG_FILT_10M = 2'h1;
   localparam logic [1:0] SOG_FILT_33M = 2'h2;
   localparam logic [1:0] SOG_FILT_BYP = 2'h3;

   // Coarse clamp filter select encodings
   localparam logic [1:0] CLP_FILT_4M8 = 2'h0;
   localparam logic [1:0] CLP_FILT_0M5 = 2'h1;
   localparam logic [1:0] CLP_FILT_1M7 = 2'h2;
   localparam logic [1:0] CLP_FILT_RSV = 2'h3;

   // Fine offset width
   localparam int FINE_W = 10;

endpackage : digitizer_ctrl_pkg

// file: src/digitizer_sync_offset_control_regs.sv
// Purpose: Register group for sync source, clock, filter, gain and offset control
// Assumes: Serial bus slave decodes the bus and presents one-cycle write and
//          read strobes with subaddress and data, on the internal reference clock
// Notes: Register fields drive the analog and sync blocks as registered controls
`timescale 1ns/1ns

// Contract
// - Sync-on-green filter select, 11 bypass default
// - Coarse clamp filter select, 00 default
// - Sync reference clock: internal or external
// - Serial bus and separator use internal clock
// - Vertical sync input A or B
// - Horizontal sync input A or B
// - Sample clock external or line-locked, default line-locked
// - Coarse gain 0.5 to 2.0, reset 1.2
// - Ten-bit fine offset from shared LSBs
// - Coarse offset sign-magnitude, four counts per step
// - Horizontal sync output start, default 0Dh
// - Sync processing reset holds sync logic
// - Luma delay adjust zero to seven
// - Copy-protection stripper enable, default on
// - Internal coast disable, ignored for external coast
// - Vertical output from separator or accumulator
// - Vertical timing bypass ignores alignment register
module digitizer_sync_offset_control_regs (
   // Clock and reset; clk is the internal reference clock
   input wire logic clk,
   input wire logic rst,
   // Register access from the serial bus slave
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   output logic reg_hit,
   // Fine offset high bits from per-channel registers elsewhere
   input wire logic [7:0] blue_fine_high,
   input wire logic [7:0] green_fine_high,
   input wire logic [7:0] red_fine_high,
   // Sync inputs and coast, already synchronised by the sync front end
   input wire logic vertical_sync_input_a,
   input wire logic vertical_sync_input_b,
   input wire logic horizontal_sync_input_a,
   input wire logic horizontal_sync_input_b,
   input wire logic internal_coast,
   input wire logic external_coast_selected,
   // Vertical sync candidates from the sync blocks
   input wire logic separator_vsync,
   input wire logic accumulator_vsync,
   input wire logic counter_timed_vsync,
   // Front-end filter controls
   output logic [1:0] sync_on_green_filter_select,
   output logic [1:0] coarse_clamp_filter_select,
   // Clock selects
   output logic sync_reference_clock_select,
   output logic sample_clock_select,
   // Routed sync and coast
   output logic selected_vsync,
   output logic selected_hsync,
   output logic coast_out,
   // Channel gain and offset
   output logic [4:0] blue_gain_tenths,
   output logic [4:0] green_gain_tenths,
   output logic [4:0] red_gain_tenths,
   output logic signed [8:0] blue_coarse_counts,
   output logic signed [8:0] green_coarse_counts,
   output logic signed [8:0] red_coarse_counts,
   output logic [digitizer_ctrl_pkg::FINE_W-1:0] blue_fine_offset,
   output logic [digitizer_ctrl_pkg::FINE_W-1:0] green_fine_offset,
   output logic [digitizer_ctrl_pkg::FINE_W-1:0] red_fine_offset,
   // Sync processing controls
   output logic [7:0] horizontal_sync_output_start,
   output logic sync_processing_reset,
   output logic [2:0] luma_delay_adjust,
   output logic copy_protection_strip_enable,
   output logic vertical_output_source_select,
   output logic vertical_timing_bypass,
   output logic alignment_reg_used,
   output logic vertical_sync_output
);
   import digitizer_ctrl_pkg::*;

   // Register storage
   logic [7:0] input_source_select_second_r;
   logic [7:0] blue_green_coarse_gain_r;
   logic [7:0] red_coarse_gain_r;
   logic [7:0] fine_offset_low_bits_r;
   logic [7:0] coarse_offset_r [3];
   logic [7:0] hsync_output_start_r;
   logic [7:0] sync_processing_control_r;
   logic [7:0] rdata_nxt;

   // Index of a coarse offset register, 3 when not one
   function automatic logic [1:0] cofs_index(input logic [7:0] a);
      unique case (a)
         ADDR_BLUE_COFS: cofs_index = 2'd0;
         ADDR_GREEN_COFS: cofs_index = 2'd1;
         ADDR_RED_COFS: cofs_index = 2'd2;
         default: cofs_index = 2'd3;
      endcase
   endfunction : cofs_index

   // True when the subaddress lies in this group
   function automatic logic addr_in_group(input logic [7:0] a);
      addr_in_group = (a >= ADDR_INPUT_SEL2) && (a <= ADDR_SP_CTRL);
   endfunction : addr_in_group

   // Scalar register writes; defaults load on reset
   always_ff @(posedge clk) begin
      if (rst) begin
         input_source_select_second_r <= RST_INPUT_SEL2;
         blue_green_coarse_gain_r <= RST_BG_GAIN;
         red_coarse_gain_r <= RST_RED_GAIN;
         fine_offset_low_bits_r <= RST_FINE_LSB;
         hsync_output_start_r <= RST_HS_START;
         sync_processing_control_r <= RST_SP_CTRL;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_INPUT_SEL2: input_source_select_second_r <= reg_wdata;
            ADDR_BG_GAIN: blue_green_coarse_gain_r <= reg_wdata;
            ADDR_RED_GAIN: red_coarse_gain_r <= reg_wdata & MASK_RED_GAIN;
            ADDR_FINE_LSB: fine_offset_low_bits_r <= reg_wdata & MASK_FINE_LSB;
            ADDR_HS_START: hsync_output_start_r <= reg_wdata;
            ADDR_SP_CTRL: sync_processing_control_r <= reg_wdata;
            default: ; // Other subaddresses hold every value
         endcase
      end
   end

   // Coarse offset registers, one per channel, addressed by index
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cofs
         always_ff @(posedge clk) begin
            if (rst) begin
               coarse_offset_r[gi] <= RST_COFS;
            end else if (reg_wr && (cofs_index(reg_addr) == 2'(gi))) begin
               coarse_offset_r[gi] <= reg_wdata & MASK_COFS;
            end
         end
      end
   endgenerate

   // Read mux; unmapped subaddresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      unique case (reg_addr)
         ADDR_INPUT_SEL2: rdata_nxt = input_source_select_second_r;
         ADDR_BG_GAIN: rdata_nxt = blue_green_coarse_gain_r;
         ADDR_RED_GAIN: rdata_nxt = red_coarse_gain_r;
         ADDR_FINE_LSB: rdata_nxt = fine_offset_low_bits_r;
         ADDR_BLUE_COFS, ADDR_GREEN_COFS, ADDR_RED_COFS: begin
            rdata_nxt = coarse_offset_r[cofs_index(reg_addr)];
         end
         ADDR_HS_START: rdata_nxt = hsync_output_start_r;
         ADDR_SP_CTRL: rdata_nxt = sync_processing_control_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Registered read answer one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
         reg_hit <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_hit <= (reg_rd || reg_wr) && addr_in_group(reg_addr);
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   // Filter and clock selects; register bank itself stays on clk whatever ref select holds
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_on_green_filter_select <= SOG_FILT_BYP;
         coarse_clamp_filter_select <= CLP_FILT_4M8;
         sync_reference_clock_select <= 1'b0;
         sample_clock_select <= 1'b1;
      end else begin
         sync_on_green_filter_select <= input_source_select_second_r[SOG_FILT_LSB +: 2];
         // Reserved clamp filter code is passed as the default filter
         if (input_source_select_second_r[CLP_FILT_LSB +: 2] == CLP_FILT_RSV) begin
            coarse_clamp_filter_select <= CLP_FILT_4M8;
         end else begin
            coarse_clamp_filter_select <= input_source_select_second_r[CLP_FILT_LSB +: 2];
         end
         sync_reference_clock_select <= input_source_select_second_r[REF_CLK_BIT];
         sample_clock_select <= input_source_select_second_r[SAMPLE_CLK_BIT];
      end
   end

   // Sync input routing and coast; all held low while sync processing is reset
   always_ff @(posedge clk) begin
      if (rst || sync_processing_control_r[SYNC_PROCESSING_RESET_BIT]) begin
         selected_vsync <= 1'b0;
         selected_hsync <= 1'b0;
         coast_out <= 1'b0;
         vertical_sync_output <= 1'b0;
      end else begin
         selected_vsync <= input_source_select_second_r[VS_IN_BIT] ?
            vertical_sync_input_b : vertical_sync_input_a;
         selected_hsync <= input_source_select_second_r[HS_IN_BIT] ?
            horizontal_sync_input_b : horizontal_sync_input_a;
         // Disable acts only on the internal coast source
         if (external_coast_selected) begin
            coast_out <= internal_coast;
         end else begin
            coast_out <= internal_coast && !sync_processing_control_r[COAST_DIS_BIT];
         end
         // Bypass takes the separator directly; else counter timed from chosen source
         if (sync_processing_control_r[VERTICAL_TIMING_BYPASS_BIT]) begin
            vertical_sync_output <= separator_vsync;
         end else if (sync_processing_control_r[VS_SRC_BIT]) begin
            vertical_sync_output <= accumulator_vsync && counter_timed_vsync;
         end else begin
            vertical_sync_output <= separator_vsync && counter_timed_vsync;
         end
      end
   end

   // Sync processing control fields
   always_ff @(posedge clk) begin
      if (rst) begin
         horizontal_sync_output_start <= RST_HS_START;
         sync_processing_reset <= 1'b0;
         luma_delay_adjust <= 3'h0;
         copy_protection_strip_enable <= 1'b1;
         vertical_output_source_select <= 1'b0;
         vertical_timing_bypass <= 1'b0;
         alignment_reg_used <= 1'b1;
      end else begin
         horizontal_sync_output_start <= hsync_output_start_r;
         sync_processing_reset <= sync_processing_control_r[SYNC_PROCESSING_RESET_BIT];
         luma_delay_adjust <= sync_processing_control_r[LUMA_DLY_LSB +: 3];
         copy_protection_strip_enable <= sync_processing_control_r[STRIP_EN_BIT];
         vertical_output_source_select <= sync_processing_control_r[VS_SRC_BIT];
         vertical_timing_bypass <= sync_processing_control_r[VERTICAL_TIMING_BYPASS_BIT];
         alignment_reg_used <= !sync_processing_control_r[VERTICAL_TIMING_BYPASS_BIT];
      end
   end

   // Fine offsets: shared low bits under per-channel high bits
   always_ff @(posedge clk) begin
      if (rst) begin
         blue_fine_offset <= '0;
         green_fine_offset <= '0;
         red_fine_offset <= '0;
      end else begin
         blue_fine_offset <= {blue_fine_high, fine_offset_low_bits_r[1:0]};
         green_fine_offset <= {green_fine_high, fine_offset_low_bits_r[3:2]};
         red_fine_offset <= {red_fine_high, fine_offset_low_bits_r[5:4]};
      end
   end

   // Gain decoders per channel
   coarse_gain_decode u_gain_blue (
      .clk(clk),
      .rst(rst),
      .code(blue_green_coarse_gain_r[3:0]),
      .gain_tenths(blue_gain_tenths)
   );
   coarse_gain_decode u_gain_green (
      .clk(clk),
      .rst(rst),
      .code(blue_green_coarse_gain_r[7:4]),
      .gain_tenths(green_gain_tenths)
   );
   coarse_gain_decode u_gain_red (
      .clk(clk),
      .rst(rst),
      .code(red_coarse_gain_r[3:0]),
      .gain_tenths(red_gain_tenths)
   );

   // Coarse offset decoders per channel
   coarse_offset_decode u_cofs_blue (
      .clk(clk),
      .rst(rst),
      .code(coarse_offset_r[0][5:0]),
      .counts(blue_coarse_counts)
   );
   coarse_offset_decode u_cofs_green (
      .clk(clk),
      .rst(rst),
      .code(coarse_offset_r[1][5:0]),
      .counts(green_coarse_counts)
   );
   coarse_offset_decode u_cofs_red (
      .clk(clk),
      .rst(rst),
      .code(coarse_offset_r[2][5:0]),
      .counts(red_coarse_counts)
   );

endmodule : digitizer_sync_offset_control_regs

// file: verif/digitizer_sync_offset_control_regs_tb.sv
// Purpose: Self-checking bench for the sync, clock and offset control registers
// Assumes: Host model drives the strobe port; bench drives the sync inputs
// Notes: Decoded outputs are compared after a settle of four clocks
`timescale 1ns/1ns
module digitizer_sync_offset_control_regs_tb;
   import digitizer_ctrl_pkg::*;
   logic clk, rst, reg_wr, reg_rd, reg_rvalid, reg_hit, ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, blue_fine_high, green_fine_high, red_fine_high, d;
   logic vertical_sync_input_a, vertical_sync_input_b, horizontal_sync_input_a;
   logic horizontal_sync_input_b, internal_coast, external_coast_selected;
   logic separator_vsync, accumulator_vsync, counter_timed_vsync, vertical_sync_output;
   logic [1:0] sync_on_green_filter_select, coarse_clamp_filter_select;
   logic sync_reference_clock_select, sample_clock_select, selected_vsync, selected_hsync;
   logic coast_out, sync_processing_reset, copy_protection_strip_enable;
   logic vertical_output_source_select, vertical_timing_bypass, alignment_reg_used;
   logic [4:0] blue_gain_tenths, green_gain_tenths, red_gain_tenths;
   logic signed [8:0] blue_coarse_counts, green_coarse_counts, red_coarse_counts;
   logic [FINE_W-1:0] blue_fine_offset, green_fine_offset, red_fine_offset;
   logic [7:0] horizontal_sync_output_start;
   logic [2:0] luma_delay_adjust;
   int bad_count, tests_run, cycles;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rb;} row_t;
   localparam row_t ROWS [10] = '{'{8'h1A, 8'h55, 8'h55}, '{8'h1B, 8'hA5, 8'hA5},
      '{8'h1C, 8'hFF, 8'h0F}, '{8'h1D, 8'hFF, 8'h3F}, '{8'h1E, 8'hFF, 8'h3F},
      '{8'h1F, 8'hC0, 8'h00}, '{8'h20, 8'h21, 8'h21}, '{8'h21, 8'hFF, 8'hFF},
      '{8'h22, 8'h7B, 8'h7B}, '{8'h23, 8'hFF, 8'h00}};
   localparam logic [7:0] DEFS [9] = '{8'hC2, 8'h77, 8'h07, 8'h00, 8'h10, 8'h10, 8'h10,
      8'h0D, 8'h08};
   localparam logic [5:0] OC [4] = '{6'h1F, 6'h20, 6'h3F, 6'h21};
   localparam logic signed [8:0] OX [4] = '{9'sd124, 9'sd0, -9'sd124, -9'sd4};

   digitizer_sync_offset_control_regs dut_u (.*);
   reg_host_model host_u (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid);

   // Free-running clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Read back one register
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host_u.read_reg(a, d, ok);
      chk(ok, 1'b1);
      chk(d, exp);
   endtask : rchk

   // Sync inputs: vsa vsb hsa hsb coast extcoast sep acc cnt
   task automatic sync_in(input logic [8:0] v);
      @(posedge clk);
      {vertical_sync_input_a, vertical_sync_input_b, horizontal_sync_input_a,
         horizontal_sync_input_b, internal_coast, external_coast_selected, separator_vsync,
         accumulator_vsync, counter_timed_vsync} <= v;
   endtask : sync_in

   // Write, then let the decoded outputs land
   task automatic wset(input logic [7:0] a, input logic [7:0] v);
      host_u.write_reg(a, v);
      repeat (4) @(posedge clk);
      #1;
   endtask : wset

   // Closing report
   task automatic results;
      $display("mismatches %0d, compares %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         results();
      end
   end

   // Main sequence
   initial begin
      rst = 1'b1;
      {vertical_sync_input_a, vertical_sync_input_b, horizontal_sync_input_a,
         horizontal_sync_input_b, internal_coast, external_coast_selected, separator_vsync,
         accumulator_vsync, counter_timed_vsync} = '0;
      blue_fine_high = 8'hA5;
      green_fine_high = 8'h3C;
      red_fine_high = 8'hFF;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(sync_on_green_filter_select, 2'h3);
      chk(coarse_clamp_filter_select, 2'h0);
      chk(sync_reference_clock_select, 1'b0);
      chk(sample_clock_select, 1'b1);
      chk(red_gain_tenths, 5'd12);
      chk(blue_fine_offset, {8'hA5, 2'b00});
      chk(green_coarse_counts, 9'sd64);
      chk(horizontal_sync_output_start, 8'h0D);
      chk(luma_delay_adjust, 3'h0);
      chk(copy_protection_strip_enable, 1'b1);
      for (int i = 0; i < 9; i++) rchk(8'h1A + 8'(i), DEFS[i]);
      for (int i = 0; i < 10; i++) begin
         host_u.write_reg(ROWS[i].a, ROWS[i].d);
         rchk(ROWS[i].a, ROWS[i].rb);
      end
      chk(horizontal_sync_output_start, 8'hFF);
      chk(luma_delay_adjust, 3'h7);
      chk(alignment_reg_used, 1'b0);
      sync_in(9'b0_1011_0101);
      wset(8'h22, 8'h7B);
      chk(vertical_sync_output, 1'b1);
      sync_in(9'b0_1011_0011);
      wset(8'h22, 8'h02);
      chk(copy_protection_strip_enable, 1'b0);
      chk(vertical_sync_output, 1'b1);
      wset(8'h22, 8'h00);
      chk(vertical_sync_output, 1'b0);
      chk(coast_out, 1'b1);
      wset(8'h22, 8'h04);
      chk(coast_out, 1'b0);
      sync_in(9'b0_1011_1011);
      wset(8'h22, 8'h04);
      chk(coast_out, 1'b1);
      wset(8'h22, 8'h80);
      chk({selected_hsync, selected_vsync, coast_out}, 3'b000);
      wset(8'h22, 8'h00);
      sync_in(9'b0_1010_0000);
      for (int k = 0; k < 4; k++) begin
         wset(8'h1A, {k[1:0], k[1:0], 4'hD});
         chk(sync_on_green_filter_select, k[1:0]);
         chk(coarse_clamp_filter_select, k == 3 ? 2'h0 : k[1:0]);
         chk({sync_reference_clock_select, sample_clock_select}, 2'b10);
         chk({selected_vsync, selected_hsync}, 2'b11);
         rchk(8'h1A, {k[1:0], k[1:0], 4'hD});
      end
      wset(8'h1A, 8'h02);
      chk({selected_vsync, selected_hsync}, 2'b00);
      wset(8'h1B, 8'hF0);
      wset(8'h1C, 8'h0F);
      chk({blue_gain_tenths, green_gain_tenths, red_gain_tenths}, {5'd5, 5'd20, 5'd20});
      for (int i = 0; i < 4; i++) begin
         for (int j = 0; j < 3; j++) host_u.write_reg(8'h1E + 8'(j), {2'b00, OC[i]});
         repeat (4) @(posedge clk);
         #1;
         chk(blue_coarse_counts, OX[i]);
         chk(green_coarse_counts, OX[i]);
         chk(red_coarse_counts, OX[i]);
      end
      wset(8'h1D, 8'h39);
      chk(blue_fine_offset, {8'hA5, 2'b01});
      chk(green_fine_offset, {8'h3C, 2'b10});
      chk(red_fine_offset, {8'hFF, 2'b11});
      host_u.write_reg(8'h19, 8'hFF);
      rchk(8'h1A, 8'h02);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rchk(8'h1A, 8'hC2);
      rchk(8'h22, 8'h08);
      results();
   end
endmodule : digitizer_sync_offset_control_regs_tb

// file: verif/reg_host_model.sv
// Purpose: Host side of the register strobe port
// Assumes: Requests launch just after a rising edge
// Notes: Address and data are inverted when idle so stale values never look valid
`timescale 1ns/1ns
module reg_host_model (
   // Clock
   input wire logic clk,
   // Requests
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   // Answers
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   // Idle levels at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // One write; the external sample clock first selects the external clamp pulse
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h1A && !d[1]) write_reg(8'h0F, 8'h80);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : write_reg

   // One read; the answer stands for one cycle after the taking edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      ok = reg_rvalid;
      d = reg_rdata;
   endtask : read_reg
endmodule : reg_host_model

// file: verif/sync_ctrl_props.sv
// Purpose: Checker for the sync, clock and offset control register group
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module by the bind after the module
`timescale 1ns/1ns
module sync_ctrl_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic reg_hit,
   // Sync candidates
   input wire logic separator_vsync,
   input wire logic accumulator_vsync,
   input wire logic counter_timed_vsync,
   // Controls and routed syncs
   input wire logic [1:0] sync_on_green_filter_select,
   input wire logic [1:0] coarse_clamp_filter_select,
   input wire logic [4:0] red_gain_tenths,
   input wire logic signed [8:0] blue_coarse_counts,
   input wire logic selected_vsync,
   input wire logic selected_hsync,
   input wire logic coast_out,
   input wire logic sync_processing_reset,
   input wire logic vertical_output_source_select,
   input wire logic vertical_timing_bypass,
   input wire logic alignment_reg_used,
   input wire logic vertical_sync_output
);
   import digitizer_ctrl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Signed counts of a sign-magnitude code
   function automatic logic signed [8:0] cofs(input logic [5:0] c);
      logic signed [8:0] m;
      m = {2'b00, c[4:0], 2'b00};
      return c[5] ? -m : m;
   endfunction : cofs

   // A write strobe to one subaddress
   sequence wr_at(logic [7:0] a);
      reg_wr && reg_addr == a;
   endsequence

   // Decoders answer two edges after the write: register, then decode
   property gain_p;
      wr_at(ADDR_RED_GAIN) |-> ##2
         red_gain_tenths == GAIN_BASE_TENTHS + 5'($past(reg_wdata[3:0], 2));
   endproperty
   property cofs_p;
      wr_at(ADDR_BLUE_COFS) |-> ##2 blue_coarse_counts == cofs($past(reg_wdata[5:0], 2));
   endproperty

   mapped_read_a:
      assert property (reg_rd && reg_addr inside {[8'h1A:8'h22]} |=> reg_rvalid && reg_hit)
      else $error("mapped read not answered");
   unmapped_read_a:
      assert property (reg_rd && !(reg_addr inside {[8'h1A:8'h22]}) |=>
         reg_rdata == 8'h00 && !reg_hit) else $error("unmapped read not zero");
   sog_filter_a:
      assert property (wr_at(ADDR_INPUT_SEL2) |-> ##2
         sync_on_green_filter_select == $past(reg_wdata[7:6], 2)) else $error("sog select wrong");
   clamp_filter_a:
      assert property (wr_at(ADDR_INPUT_SEL2) |-> ##2 coarse_clamp_filter_select ==
         ($past(reg_wdata[5:4], 2) == CLP_FILT_RSV ? CLP_FILT_4M8 : $past(reg_wdata[5:4], 2)))
      else $error("clamp select wrong");
   red_gain_a:
      assert property (gain_p) else $error("gain decode wrong");
   blue_offset_a:
      assert property (cofs_p) else $error("coarse offset decode wrong");
   sync_reset_hold_a:
      assert property (sync_processing_reset |->
         !(selected_vsync || selected_hsync || coast_out || vertical_sync_output))
      else $error("sync output during sync reset");
   bypass_path_a:
      assert property (vertical_timing_bypass && !sync_processing_reset && !$past(rst) |->
         vertical_sync_output == $past(separator_vsync)) else $error("bypass path wrong");
   vs_source_a:
      assert property (!vertical_timing_bypass && !sync_processing_reset && !$past(rst) |->
         vertical_sync_output == ((vertical_output_source_select ? $past(accumulator_vsync)
         : $past(separator_vsync)) && $past(counter_timed_vsync))) else $error("vs source wrong");
   align_used_a:
      assert property (alignment_reg_used != vertical_timing_bypass)
      else $error("alignment use wrong");
endmodule : sync_ctrl_props

bind digitizer_sync_offset_control_regs sync_ctrl_props chk_u (.clk, .rst, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_hit, .separator_vsync,
   .accumulator_vsync, .counter_timed_vsync, .sync_on_green_filter_select,
   .coarse_clamp_filter_select, .red_gain_tenths, .blue_coarse_counts, .selected_vsync,
   .selected_hsync, .coast_out, .sync_processing_reset, .vertical_output_source_select,
   .vertical_timing_bypass, .alignment_reg_used, .vertical_sync_output);
